// ==== verilog/dual_dac_pkg.sv ====
// Purpose : constants for the dual converter input front end
// Assumes : one AHB-Lite slave, 32-bit words, link logic on sample_clock
// Notes   : all offsets are byte addresses
//
// Notes on behaviour
// - Full skip sends samples around every filter and correction stage.
// - Filter skip drops only the interpolation filter stages.
// - A four-entry input buffer is used unless buffer skip is set.
// - Each channel's first filter is highpass when its type bit is set, else lowpass.
// - With PLL off and two-clock on, input is captured on the data latch clock.
// - In shared-bus mode A and B words alternate on bus A and are split apart.
// - In split-bus mode the bus A and bus B words of each capture are interleaved into one A stream.
// - The serial pin-count bit selects four-wire when set and three-wire when clear.
// - Otherwise input is captured on the lock pin rising edge, or falling if inverted while the PLL is off.
// - The marker pin tags B words when enabled; else the gate rising edge aligns A/B.
// - Input is two's complement when the signed bit is set, else offset binary.
// - Pin 15 is the MSB unless the channel's reverse bit flips the order.
// - Upper sideband inverts the data going to the second converter.
// - Interpolation factor is selectable as two, four, four low power or eight.
package dual_dac_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_ADDR   = 32'h0000_0000;
  localparam logic [31:0] STATUS_ADDR = 32'h0000_0004;
  localparam int          CTRL_W      = 18;
  localparam logic [17:0] CTRL_RESET  = 18'h00000;
  localparam int          STAT_W      = 4;

  // ----------------------------------------------------------------
  // control bit positions
  // ----------------------------------------------------------------
  localparam int B_FULL_SKIP   = 0;
  localparam int B_FILTER_SKIP = 1;
  localparam int B_BUFFER_SKIP = 2;
  localparam int B_TYPE_A      = 3;
  localparam int B_TYPE_B      = 4;
  localparam int B_TWO_CLOCK   = 5;
  localparam int B_PLL_ENABLE  = 6;
  localparam int B_LOCK_INV    = 7;
  localparam int B_SHARED_BUS  = 8;
  localparam int B_SPLIT_BUS   = 9;
  localparam int B_MARKER      = 10;
  localparam int B_SIGNED      = 11;
  localparam int B_REVERSE_A   = 12;
  localparam int B_REVERSE_B   = 13;
  localparam int B_UPPER_SB    = 14;
  localparam int B_FOUR_WIRE   = 15;
  localparam int B_INTERP_LO   = 16;
  localparam int B_INTERP_HI   = 17;

  // ----------------------------------------------------------------
  // datapath constants
  // ----------------------------------------------------------------
  localparam logic [15:0] MSB_FLIP = 16'h8000;
  localparam logic [2:0]  HALF_X2  = 3'h1;
  localparam logic [2:0]  HALF_X4  = 3'h2;
  localparam logic [2:0]  HALF_X8  = 3'h4;

  typedef enum logic [1:0] {
    INTERP_X2  = 2'h0,
    INTERP_X4  = 2'h1,
    INTERP_X4L = 2'h2,
    INTERP_X8  = 2'h3
  } interp_t;

  typedef enum logic {
    PH_A = 1'h0,
    PH_B = 1'h1
  } phase_t;

endpackage : dual_dac_pkg

// ==== verilog/dual_dac_front.sv ====
// Purpose : register file and input front end of a dual interpolating converter
// Assumes : config is quasi-static, so a two-flop copy into the link domain is safe
// Notes   : capture edges are sampled on sample_clock, which must be the fastest clock
`timescale 1ns/1ps
`default_nettype none
module dual_dac_front #(
  parameter int DEPTH = 4
) (
  // bus side
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // link side
  input  wire logic        sample_clock,
  input  wire logic        data_latch_clock,
  input  wire logic [15:0] bus_a_pins,
  input  wire logic [15:0] bus_b_pins,
  input  wire logic        b_marker_pin,
  input  wire logic        tx_gate_pin,
  output logic             lock_output_pin,
  output logic             serial_four_wire,
  // converter cores
  output logic      [15:0] conv_a_code,
  output logic      [15:0] conv_b_code
);

  localparam int CW = dual_dac_pkg::CTRL_W;
  localparam int PW = $clog2(DEPTH);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [CW-1:0]                  ctrl;
    logic                           wr_pend;
    logic [31:0]                    rdata;
    logic [dual_dac_pkg::STAT_W-1:0] st_meta;
    logic [dual_dac_pkg::STAT_W-1:0] st_sync;
  } bus_t;

  typedef struct packed {
    logic [CW-1:0]              cfg_meta;
    logic [CW-1:0]              cfg;
    logic [15:0]                a_meta;
    logic [15:0]                a_sync;
    logic [15:0]                b_meta;
    logic [15:0]                b_sync;
    logic [2:0]                 pin_meta;
    logic [2:0]                 pin_sync;
    logic                       dclk_prev;
    logic                       tx_prev;
    logic [2:0]                 div_cnt;
    logic                       lock_out;
    logic                       lock_prev;
    logic [DEPTH-1:0][31:0]     fifo;
    logic [PW:0]                wr_ptr;
    logic [PW:0]                rd_ptr;
    dual_dac_pkg::phase_t       phase;
    logic                       held_ok;
    logic [15:0]                held_a;
    logic                       split_pend;
    logic [15:0]                split_word;
    logic [15:0]                cur_a;
    logic [15:0]                cur_b;
    logic [15:0]                prev_a;
    logic [15:0]                prev_b;
    logic [15:0]                out_a;
    logic [15:0]                out_b;
  } link_t;

  bus_t  b;
  bus_t  next_b;
  link_t l;
  link_t next_l;
  logic  [1:0] lrst_sync;
  logic        lrst_n;
  logic [15:0] a_rev;
  logic [15:0] b_rev;
  logic        fifo_full;
  logic        fifo_empty;

  assign lrst_n = lrst_sync[1];

  // ------------------------------------------------------------
  // link reset: async assert, release synchronised to sample_clock
  // ------------------------------------------------------------
  always_ff @(posedge sample_clock or negedge hresetn)
  begin
    if (!hresetn)
      lrst_sync <= 2'h0;
    else
      lrst_sync <= {lrst_sync[0], 1'h1};
  end

  // ------------------------------------------------------------
  // bus slave, zero wait states
  // ------------------------------------------------------------
  assign hreadyout        = 1'h1;
  assign hresp            = 1'h0;
  assign hrdata           = b.rdata;
  assign serial_four_wire = b.ctrl[dual_dac_pkg::B_FOUR_WIRE];

  always_comb
  begin
    logic sel;
    sel    = hsel & htrans[1] & hready;
    next_b = b;
    next_b.st_meta = {l.lock_out, l.phase == dual_dac_pkg::PH_B, fifo_full, fifo_empty};
    next_b.st_sync = b.st_meta;
    if (b.wr_pend)
      next_b.ctrl = hwdata[CW-1:0];
    next_b.wr_pend = sel & hwrite & (haddr == dual_dac_pkg::CTRL_ADDR);
    if (sel & !hwrite)
    begin
      if (haddr == dual_dac_pkg::CTRL_ADDR)
        next_b.rdata = {{(32 - CW){1'b0}}, next_b.ctrl};
      else if (haddr == dual_dac_pkg::STATUS_ADDR)
        next_b.rdata = {{(32 - dual_dac_pkg::STAT_W){1'b0}}, b.st_sync};
      else
        next_b.rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      b <= '{ctrl: dual_dac_pkg::CTRL_RESET, rdata: 32'h0000_0000, default: '0};
    else
      b <= next_b;
  end

  // ------------------------------------------------------------
  // bit order per channel
  // ------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 16; i++)
    begin : g_rev
      assign a_rev[i] = l.cfg[dual_dac_pkg::B_REVERSE_A] ? l.a_sync[15 - i] : l.a_sync[i];
      assign b_rev[i] = l.cfg[dual_dac_pkg::B_REVERSE_B] ? l.b_sync[15 - i] : l.b_sync[i];
    end
  endgenerate

  assign fifo_empty = (l.wr_ptr == l.rd_ptr);
  assign fifo_full  = (l.wr_ptr == (l.rd_ptr ^ {1'b1, {PW{1'b0}}}));

  // ------------------------------------------------------------
  // link datapath
  // ------------------------------------------------------------
  always_comb
  begin
    logic [2:0]  half;
    logic        dual, cap, tick, tx_rise, is_b, push, load;
    logic [31:0] push_word, ld_word;
    logic [15:0] wa, wb, ya, yb;
    logic [16:0] fa, fb;
    half = dual_dac_pkg::HALF_X2;
    dual = 1'b0; cap = 1'b0; tick = 1'b0; tx_rise = 1'b0; is_b = 1'b0;
    push = 1'b0; push_word = 32'h0000_0000; load = 1'b0; ld_word = 32'h0000_0000;
    fa = 17'h00000; fb = 17'h00000; ya = 16'h0000; yb = 16'h0000; wa = 16'h0000; wb = 16'h0000;
    next_l = l;
    next_l.cfg_meta  = b.ctrl;
    next_l.cfg       = l.cfg_meta;
    next_l.a_meta    = bus_a_pins;
    next_l.a_sync    = l.a_meta;
    next_l.b_meta    = bus_b_pins;
    next_l.b_sync    = l.b_meta;
    next_l.pin_meta  = {data_latch_clock, b_marker_pin, tx_gate_pin};
    next_l.pin_sync  = l.pin_meta;
    next_l.dclk_prev = l.pin_sync[2];
    next_l.tx_prev   = l.pin_sync[0];
    next_l.lock_prev = l.lock_out;
    // offset binary input becomes internal two's complement
    wa = l.cfg[dual_dac_pkg::B_SIGNED] ? a_rev : a_rev ^ dual_dac_pkg::MSB_FLIP;
    wb = l.cfg[dual_dac_pkg::B_SIGNED] ? b_rev : b_rev ^ dual_dac_pkg::MSB_FLIP;

    // lock pin runs at update rate over the interpolation factor
    case (dual_dac_pkg::interp_t'(l.cfg[dual_dac_pkg::B_INTERP_HI:dual_dac_pkg::B_INTERP_LO]))
      dual_dac_pkg::INTERP_X2:  half = dual_dac_pkg::HALF_X2;
      dual_dac_pkg::INTERP_X4, dual_dac_pkg::INTERP_X4L: half = dual_dac_pkg::HALF_X4;
      dual_dac_pkg::INTERP_X8:  half = dual_dac_pkg::HALF_X8;
      default:                  half = dual_dac_pkg::HALF_X2;
    endcase
    if (l.div_cnt >= half - 3'h1)
    begin
      next_l.div_cnt  = 3'h0;
      next_l.lock_out = ~l.lock_out;
      tick            = l.cfg[dual_dac_pkg::B_SPLIT_BUS] | !l.lock_out;
    end
    else
      next_l.div_cnt = l.div_cnt + 3'h1;

    dual = l.cfg[dual_dac_pkg::B_TWO_CLOCK] & !l.cfg[dual_dac_pkg::B_PLL_ENABLE];
    if (dual)
      cap = l.pin_sync[2] & !l.dclk_prev;
    else if (l.cfg[dual_dac_pkg::B_LOCK_INV] & !l.cfg[dual_dac_pkg::B_PLL_ENABLE])
      cap = l.lock_prev & !l.lock_out;
    else
      cap = !l.lock_prev & l.lock_out;
    tx_rise = l.pin_sync[0] & !l.tx_prev;

    if (l.split_pend)
    begin
      push              = 1'b1;
      push_word         = {l.split_word, 16'h0000};
      next_l.split_pend = 1'b0;
    end
    if (cap)
    begin
      if (l.cfg[dual_dac_pkg::B_SHARED_BUS])
      begin
        is_b = l.cfg[dual_dac_pkg::B_MARKER] ? l.pin_sync[1] : (l.phase == dual_dac_pkg::PH_B);
        next_l.phase = is_b ? dual_dac_pkg::PH_A : dual_dac_pkg::PH_B;
        if (is_b & l.held_ok)
        begin
          push           = 1'b1;
          push_word      = {l.held_a, wa};
          next_l.held_ok = 1'b0;
        end
        else if (!is_b)
        begin
          next_l.held_a  = wa;
          next_l.held_ok = 1'b1;
        end
      end
      else if (l.cfg[dual_dac_pkg::B_SPLIT_BUS])
      begin
        push              = 1'b1;
        push_word         = {wa, 16'h0000};
        next_l.split_pend = 1'b1;
        next_l.split_word = wb;
      end
      else
      begin
        push      = 1'b1;
        push_word = {wa, wb};
      end
    end
    if (tx_rise & !l.cfg[dual_dac_pkg::B_MARKER])
    begin
      next_l.phase   = dual_dac_pkg::PH_A;
      next_l.held_ok = 1'b0;
    end

    // input buffer; a gate rising edge realigns its pointers
    if (l.cfg[dual_dac_pkg::B_BUFFER_SKIP])
    begin
      load    = push;
      ld_word = push_word;
    end
    else
    begin
      if (push & !fifo_full)
      begin
        next_l.fifo[l.wr_ptr[PW-1:0]] = push_word;
        next_l.wr_ptr = l.wr_ptr + 1'b1;
      end
      if (tick & !fifo_empty)
      begin
        load    = 1'b1;
        ld_word = l.fifo[l.rd_ptr[PW-1:0]];
        next_l.rd_ptr = l.rd_ptr + 1'b1;
      end
    end
    if (tx_rise)
    begin
      next_l.wr_ptr = '0;
      next_l.rd_ptr = '0;
    end
    if (load)
    begin
      next_l.prev_a = l.cur_a;
      next_l.prev_b = l.cur_b;
      next_l.cur_a  = ld_word[31:16];
      next_l.cur_b  = ld_word[15:0];
    end

    // first filter stage: half sum or half difference of neighbours
    fa = l.cfg[dual_dac_pkg::B_TYPE_A] ? {l.cur_a[15], l.cur_a} - {l.prev_a[15], l.prev_a}
                                       : {l.cur_a[15], l.cur_a} + {l.prev_a[15], l.prev_a};
    fb = l.cfg[dual_dac_pkg::B_TYPE_B] ? {l.cur_b[15], l.cur_b} - {l.prev_b[15], l.prev_b}
                                       : {l.cur_b[15], l.cur_b} + {l.prev_b[15], l.prev_b};
    if (l.cfg[dual_dac_pkg::B_FULL_SKIP])
    begin
      ya = l.cur_a;
      yb = l.cur_b;
    end
    else
    begin
      ya = l.cfg[dual_dac_pkg::B_FILTER_SKIP] ? l.cur_a : fa[16:1];
      yb = l.cfg[dual_dac_pkg::B_FILTER_SKIP] ? l.cur_b : fb[16:1];
      if (l.cfg[dual_dac_pkg::B_UPPER_SB])
        yb = 16'h0000 - yb;
    end
    next_l.out_a = ya ^ dual_dac_pkg::MSB_FLIP;
    next_l.out_b = yb ^ dual_dac_pkg::MSB_FLIP;
  end

  always_ff @(posedge sample_clock or negedge lrst_n)
  begin
    if (!lrst_n)
      l <= '{cfg_meta: dual_dac_pkg::CTRL_RESET, cfg: dual_dac_pkg::CTRL_RESET,
             out_a: dual_dac_pkg::MSB_FLIP, out_b: dual_dac_pkg::MSB_FLIP,
             phase: dual_dac_pkg::PH_A, default: '0};
    else
      l <= next_l;
  end

  assign lock_output_pin = l.lock_out;
  assign conv_a_code     = l.out_a;
  assign conv_b_code     = l.out_b;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_ctrl_write;
    b.wr_pend;
  endsequence

  sequence s_lock_rise;
    !l.lock_prev && l.lock_out;
  endsequence

  a_ctrl_write_load: assert property (@(posedge hclk) disable iff (!hresetn)
    s_ctrl_write |=> b.ctrl == $past(hwdata[CW-1:0]))
    else $error("control word not loaded from write");
  a_ctrl_value_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !b.wr_pend |=> $stable(b.ctrl))
    else $error("control word changed without write");
  a_four_wire_pin: assert property (@(posedge hclk) disable iff (!hresetn)
    s_ctrl_write ##1 1'b1 |-> serial_four_wire == $past(hwdata[dual_dac_pkg::B_FOUR_WIRE]))
    else $error("serial pin-count output wrong after write");
  a_full_skip_path: assert property (@(posedge sample_clock) disable iff (!lrst_n)
    l.cfg[dual_dac_pkg::B_FULL_SKIP] |=> l.out_b == ($past(l.cur_b) ^ dual_dac_pkg::MSB_FLIP))
    else $error("full skip did not pass sample through");
  a_filter_skip_path: assert property (@(posedge sample_clock) disable iff (!lrst_n)
    l.cfg[dual_dac_pkg::B_FILTER_SKIP] |=> l.out_a == ($past(l.cur_a) ^ dual_dac_pkg::MSB_FLIP))
    else $error("filter skip did not pass sample through");
  a_lowpass_stage: assert property (@(posedge sample_clock) disable iff (!lrst_n)
    !l.cfg[dual_dac_pkg::B_FULL_SKIP] && !l.cfg[dual_dac_pkg::B_FILTER_SKIP]
    && !l.cfg[dual_dac_pkg::B_TYPE_A] && l.cur_a == l.prev_a
    |=> l.out_a == ($past(l.cur_a) ^ dual_dac_pkg::MSB_FLIP))
    else $error("lowpass of equal samples not unity");
  a_usb_invert: assert property (@(posedge sample_clock) disable iff (!lrst_n)
    l.cfg[dual_dac_pkg::B_UPPER_SB] && l.cfg[dual_dac_pkg::B_FILTER_SKIP]
    && !l.cfg[dual_dac_pkg::B_FULL_SKIP]
    |=> l.out_b == ((16'h0000 - $past(l.cur_b)) ^ dual_dac_pkg::MSB_FLIP))
    else $error("second converter data not inverted");
  a_buffer_skip_ptr: assert property (@(posedge sample_clock) disable iff (!lrst_n)
    l.cfg[dual_dac_pkg::B_BUFFER_SKIP] && !(l.pin_sync[0] && !l.tx_prev) |=> $stable(l.wr_ptr))
    else $error("buffer written while skipped");
  a_lock_rise_cap: assert property (@(posedge sample_clock) disable iff (!lrst_n)
    s_lock_rise ##0 (l.cfg[dual_dac_pkg::B_INTERP_HI:0] == '0) ##0 !fifo_full
    ##0 !(l.pin_sync[0] && !l.tx_prev) |=> l.wr_ptr == $past(l.wr_ptr) + 1'b1)
    else $error("lock rising edge did not capture a word");

endmodule : dual_dac_front
`default_nettype wire

// ==== verification/src_model.sv ====
// Purpose : behavioural sample source standing in for the pattern generator
// Assumes : the front end's lock pin paces the words
// Notes   : words change on the lock falling edge, half a period before capture
`timescale 1ns/1ps
`default_nettype none
module src_model #(
  parameter int DLC_HALF = 2
) (
  // pacing
  input  wire logic        clk,
  input  wire logic        lock,
  // scenario controls
  input  wire logic        shared,
  input  wire logic        gate_en,
  input  wire logic        run_dlc,
  input  wire logic [15:0] wa,
  input  wire logic [15:0] wb,
  // sample buses
  output logic      [15:0] bus_a,
  output logic      [15:0] bus_b,
  output logic             marker,
  output logic             gate,
  output logic             dlc
);
  logic lock_q = 1'b0;
  logic ph     = 1'b0;
  int   cnt    = 0;

  initial
  begin
    bus_a  = 16'h0000;
    bus_b  = 16'hFFFF;
    marker = 1'b0;
    gate   = 1'b0;
    dlc    = 1'b0;
  end

  // changing on the fall leaves the synchroniser a full half period to settle
  always @(posedge clk)
  begin
    lock_q <= lock;
    if (lock_q && !lock)
    begin
      ph     <= ~ph;
      bus_a  <= (shared && ph) ? wb : wa;
      bus_b  <= shared ? ~bus_b : wb;
      marker <= shared && ph;
      gate   <= gate_en && !ph;
    end
    // the data clock stands still unless a scenario runs it
    if (run_dlc)
    begin
      cnt <= (cnt == DLC_HALF - 1) ? 0 : cnt + 1;
      if (cnt == DLC_HALF - 1)
        dlc <= ~dlc;
    end
    else
    begin
      cnt <= 0;
      dlc <= 1'b0;
    end
  end
endmodule : src_model
`default_nettype wire

// ==== verification/tb_dual_dac_front.sv ====
// Purpose : self-checking bench for the dual converter input front end
// Assumes : src_model feeds the buses; codes are compared once settled
// Notes   : constant words make every filter result exact
`timescale 1ns/1ps
`default_nettype none
module tb_dual_dac_front;
  localparam logic [31:0] FS = 32'h1 << dual_dac_pkg::B_FULL_SKIP;
  localparam logic [31:0] FK = 32'h1 << dual_dac_pkg::B_FILTER_SKIP;
  localparam logic [31:0] BK = 32'h1 << dual_dac_pkg::B_BUFFER_SKIP;
  localparam logic [31:0] TA = 32'h1 << dual_dac_pkg::B_TYPE_A;
  localparam logic [31:0] TB = 32'h1 << dual_dac_pkg::B_TYPE_B;
  localparam logic [31:0] TC = 32'h1 << dual_dac_pkg::B_TWO_CLOCK;
  localparam logic [31:0] LI = 32'h1 << dual_dac_pkg::B_LOCK_INV;
  localparam logic [31:0] SH = 32'h1 << dual_dac_pkg::B_SHARED_BUS;
  localparam logic [31:0] SP = 32'h1 << dual_dac_pkg::B_SPLIT_BUS;
  localparam logic [31:0] MK = 32'h1 << dual_dac_pkg::B_MARKER;
  localparam logic [31:0] SG = 32'h1 << dual_dac_pkg::B_SIGNED;
  localparam logic [31:0] RA = 32'h1 << dual_dac_pkg::B_REVERSE_A;
  localparam logic [31:0] RB = 32'h1 << dual_dac_pkg::B_REVERSE_B;
  localparam logic [31:0] US = 32'h1 << dual_dac_pkg::B_UPPER_SB;
  localparam logic [31:0] FW = 32'h1 << dual_dac_pkg::B_FOUR_WIRE;
  localparam logic [31:0] X8 = 32'h3 << dual_dac_pkg::B_INTERP_LO;
  localparam logic [31:0] CT = dual_dac_pkg::CTRL_ADDR;
  localparam logic [31:0] ST = dual_dac_pkg::STATUS_ADDR;

  typedef struct packed {
    logic [31:0] c;
    logic [15:0] a, b, ea, eb;
  } row_t;

  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic        sample_clock, data_latch_clock, marker, gate, lock_output_pin;
  logic        serial_four_wire, shared, gate_en, run_dlc;
  logic [15:0] bus_a, bus_b, conv_a, conv_b, wa, wb;
  logic [1:0]  seen;
  int          err_total, checks, n;
  logic [31:0] per [4] = '{32'h2, 32'h4, 32'h4, 32'h8};
  row_t        tab [10] = '{
    '{FS | X8, 16'h1234, 16'h5678, 16'h1234, 16'h5678},
    '{FS | X8 | US, 16'hC000, 16'hC000, 16'hC000, 16'hC000},
    '{FS | X8 | SG, 16'h1234, 16'hF000, 16'h9234, 16'h7000},
    '{FS | X8 | RA | RB, 16'h0003, 16'h000F, 16'hC000, 16'hF000},
    '{FS | X8 | LI, 16'h0F0F, 16'hF0F0, 16'h0F0F, 16'hF0F0},
    '{FS | X8 | BK, 16'h4321, 16'h8765, 16'h4321, 16'h8765},
    '{X8, 16'h1234, 16'h5678, 16'h1234, 16'h5678},
    '{X8 | TA, 16'h1234, 16'h5678, 16'h8000, 16'h5678},
    '{X8 | TB, 16'h1234, 16'h5678, 16'h1234, 16'h8000},
    '{X8 | FK | TA | TB, 16'h1234, 16'h5678, 16'h1234, 16'h5678}};

  dual_dac_front #(.DEPTH(4)) i_dual_dac_front (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sample_clock(sample_clock),
    .data_latch_clock(data_latch_clock), .bus_a_pins(bus_a), .bus_b_pins(bus_b),
    .b_marker_pin(marker), .tx_gate_pin(gate), .lock_output_pin(lock_output_pin),
    .serial_four_wire(serial_four_wire), .conv_a_code(conv_a), .conv_b_code(conv_b));

  src_model #(.DLC_HALF(2)) i_src_model (
    .clk(sample_clock), .lock(lock_output_pin), .shared(shared), .gate_en(gate_en),
    .run_dlc(run_dlc), .wa(wa), .wb(wb), .bus_a(bus_a), .bus_b(bus_b),
    .marker(marker), .gate(gate), .dlc(data_latch_clock));

  always #50 hclk = ~hclk;
  always #6 sample_clock = ~sample_clock;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", s, exp, got);
    end
  endtask : chk

  task automatic ready_edge(inout int k);
    @(posedge hclk);
    while (hreadyout !== 1'b1 && k < 64)
    begin
      @(posedge hclk);
      k++;
    end
  endtask : ready_edge

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    ready_edge(k);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    ready_edge(k);
    q = hrdata;
    if (k >= 64)
    begin
      err_total++;
      end_of_test;
    end
  endtask : xfer

  task automatic settle;
    repeat (100) @(negedge sample_clock);
  endtask : settle

  task automatic lock_period(output int m);
    logic p;
    int   hits, k;
    p = lock_output_pin;
    hits = 0;
    k = 0;
    m = 0;
    while (hits < 2 && k < 200)
    begin
      @(negedge sample_clock);
      k++;
      m++;
      if (lock_output_pin === 1'b1 && p === 1'b0)
      begin
        hits++;
        if (hits == 1)
          m = 0;
      end
      p = lock_output_pin;
    end
    if (k >= 200)
    begin
      err_total++;
      end_of_test;
    end
  endtask : lock_period

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    #1000000;
    err_total++;
    end_of_test;
  end

  initial
  begin
    {hclk, hresetn, hsel, hwrite, shared, gate_en, run_dlc} = 7'h00;
    {haddr, hwdata, htrans, wa, wb} = 98'h0;
    sample_clock = 1'b1;
    err_total = 0;
    checks = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, CT, 32'h0);
    chk("ctrl_reset", q, 32'h0);
    chk("hresp_okay", {31'h0, hresp}, 32'h0);
    xfer(1'b1, CT, FW);
    settle;
    chk("four_wire_on", {31'h0, serial_four_wire}, 32'h1);
    xfer(1'b1, 32'h0000_0010, 32'hFFFF_FFFF);
    xfer(1'b0, 32'h0000_0010, 32'h0);
    chk("unmapped", q, 32'h0);
    xfer(1'b0, CT, 32'h0);
    chk("ctrl_hold", q, FW);
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'b1, CT, 32'(i) << dual_dac_pkg::B_INTERP_LO);
      settle;
      lock_period(n);
      chk("lock_period", 32'(n), per[i]);
    end
    chk("four_wire_off", {31'h0, serial_four_wire}, 32'h0);
    foreach (tab[i])
    begin
      wa <= tab[i].a;
      wb <= tab[i].b;
      xfer(1'b1, CT, tab[i].c);
      settle;
      chk("conv_a", {16'h0, conv_a}, {16'h0, tab[i].ea});
      chk("conv_b", {16'h0, conv_b}, {16'h0, tab[i].eb});
    end
    xfer(1'b1, CT, X8 | FK | US);
    settle;
    chk("sideband_codes", {conv_a, conv_b}, {16'h1234, 16'hA988});
    shared <= 1'b1;
    wa <= 16'h1111;
    wb <= 16'h2222;
    for (int i = 0; i < 2; i++)
    begin
      gate_en <= i[0];
      xfer(1'b1, CT, i == 0 ? FS | X8 | SH | MK : FS | X8 | SH);
      settle;
      chk("shared_a", {16'h0, conv_a}, 32'h1111);
      chk("shared_b", {16'h0, conv_b}, 32'h2222);
    end
    shared <= 1'b0;
    gate_en <= 1'b0;
    wa <= 16'h0AAA;
    wb <= 16'h0BBB;
    xfer(1'b1, CT, FS | X8 | SP);
    settle;
    seen = 2'h0;
    repeat (40)
    begin
      @(negedge sample_clock);
      seen = seen | {conv_a === 16'h0AAA, conv_a === 16'h0BBB};
    end
    chk("split_words", {30'h0, seen}, 32'h3);
    xfer(1'b1, CT, FS | X8 | TC);
    settle;
    wa <= 16'h1357;
    wb <= 16'h2468;
    settle;
    xfer(1'b0, ST, 32'h0);
    chk("status_empty", q & 32'h3, 32'h1);
    chk("no_capture", {31'h0, conv_a === 16'h1357}, 32'h0);
    run_dlc <= 1'b1;
    settle;
    seen = 2'h0;
    // each pop frees a slot for a few cycles, so read at drifting phases
    repeat (8)
    begin
      xfer(1'b0, ST, 32'h0);
      seen[1] = seen[1] | (q[1:0] === 2'h2);
    end
    chk("status_full", {31'h0, seen[1]}, 32'h1);
    chk("latched_a", {16'h0, conv_a}, 32'h1357);
    chk("latched_b", {16'h0, conv_b}, 32'h2468);
    run_dlc <= 1'b0;
    settle;
    xfer(1'b0, ST, 32'h0);
    chk("status_drained", q & 32'h3, 32'h1);
    end_of_test;
  end
endmodule : tb_dual_dac_front
`default_nettype wire
